// [rtl/boot_status_pkg.sv]
// Functional notes
// - A failed serial EEPROM read sets the boot_load_failed flag, bit 0 of byte 0214, which holds until reset.
// - The end of the EEPROM read cycle sets the config_load_done flag, bit 0 of byte 0215, which holds until reset.
// - Bit 3 of byte 0215, config_checksum_ok, reads 0 after a CRC failure on a found EEPROM and 1 otherwise.
// - After a CRC failure the host serial port stays locked and register access is refused until hardware reset.
// - Reserved bits, and the whole of byte 0213, are written as zero by the host; this block reads them as zero.
package boot_status_pkg;

    localparam logic [15:0] ADDR_GLOBAL_RSVD = 16'h0213;
    localparam logic [15:0] ADDR_BOOT_FAIL   = 16'h0214;
    localparam logic [15:0] ADDR_LOAD_STATUS = 16'h0215;

    localparam int BIT_BOOT_FAILED = 0;
    localparam int BIT_LOAD_DONE   = 0;
    localparam int BIT_CHECKSUM_OK = 3;

    localparam logic RST_FAILED      = 1'b0;
    localparam logic RST_DONE        = 1'b0;
    localparam logic RST_CHECKSUM_OK = 1'b1;
    localparam logic RST_LOCKED      = 1'b0;

    // Loader events reported by the EEPROM read engine
    typedef struct packed {
        logic read_done;
        logic read_error;
        logic crc_error;
    } loader_event_t;

    // Host register read request and answer
    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } reg_req_t;

    typedef struct packed {
        logic       ack;
        logic       refused;
        logic [7:0] data;
    } reg_rsp_t;

    typedef enum logic [1:0] {
        LOAD_IDLE,
        LOAD_BUSY,
        LOAD_DONE
    } load_state_t;

endpackage

// [rtl/reset_sync.sv]
module reset_sync (
    // Clock and raw reset
    input  wire logic sys_clk,
    input  wire logic arst_n,
    // Released reset
    output logic      rst_n
);

    logic meta_r;
    logic sync_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= 1'b1;
            sync_r <= meta_r;
        end
    end

    assign rst_n = sync_r;

endmodule // reset_sync

// [rtl/eeprom_boot_status.sv]
module eeprom_boot_status (
    // Clock and reset; arst_n is the hard_reset_pin
    input  wire logic                          sys_clk,
    input  wire logic                          arst_n,
    // EEPROM read engine
    input  wire boot_status_pkg::loader_event_t load_evt,
    output logic                               load_start,
    // Host register port
    input  wire boot_status_pkg::reg_req_t     reg_req,
    output boot_status_pkg::reg_rsp_t          reg_rsp,
    // Status
    output logic                               port_locked,
    output logic                               boot_load_failed,
    output logic                               config_load_done,
    output logic                               config_checksum_ok
);

    logic rst_n;

    reset_sync u_reset_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .rst_n   (rst_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Load sequencing and sticky flags

    boot_status_pkg::load_state_t state_r, state_nxt;
    logic failed_r, failed_nxt;
    logic done_r, done_nxt;
    logic crc_ok_r, crc_ok_nxt;
    logic locked_r, locked_nxt;
    logic start_r, start_nxt;

    always_comb begin
        state_nxt  = state_r;
        failed_nxt = failed_r;
        done_nxt   = done_r;
        crc_ok_nxt = crc_ok_r;
        locked_nxt = locked_r;
        start_nxt  = 1'b0;
        case (state_r)
            boot_status_pkg::LOAD_IDLE: begin
                // A fresh load starts once reset is released
                state_nxt = boot_status_pkg::LOAD_BUSY;
                start_nxt = 1'b1;
            end
            boot_status_pkg::LOAD_BUSY: begin
                if (load_evt.read_error) begin
                    failed_nxt = 1'b1;
                end
                if (load_evt.crc_error) begin
                    crc_ok_nxt = 1'b0;
                    locked_nxt = 1'b1;
                end
                if (load_evt.read_done) begin
                    done_nxt  = 1'b1;
                    state_nxt = boot_status_pkg::LOAD_DONE;
                end
            end
            boot_status_pkg::LOAD_DONE: begin
                // Flags are frozen; only reset leaves this state
                state_nxt = boot_status_pkg::LOAD_DONE;
            end
            default: state_nxt = boot_status_pkg::LOAD_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= boot_status_pkg::LOAD_IDLE;
            failed_r <= boot_status_pkg::RST_FAILED;
            done_r   <= boot_status_pkg::RST_DONE;
            crc_ok_r <= boot_status_pkg::RST_CHECKSUM_OK;
            locked_r <= boot_status_pkg::RST_LOCKED;
            start_r  <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            failed_r <= failed_nxt;
            done_r   <= done_nxt;
            crc_ok_r <= crc_ok_nxt;
            locked_r <= locked_nxt;
            start_r  <= start_nxt;
        end
    end

    assign load_start         = start_r;
    assign port_locked        = locked_r;
    assign boot_load_failed   = failed_r;
    assign config_load_done   = done_r;
    assign config_checksum_ok = crc_ok_r;

    ////////////////////////////////////////////////////////////////////////////
    // Register read port

    boot_status_pkg::reg_rsp_t rsp_r, rsp_nxt;

    always_comb begin
        rsp_nxt = '0;
        if (reg_req.rd) begin
            if (locked_r) begin
                // A locked port refuses the read and returns no data
                rsp_nxt.refused = 1'b1;
            end else begin
                rsp_nxt.ack = 1'b1;
                // Reserved bits and unmapped bytes read as zero
                case (reg_req.addr)
                    boot_status_pkg::ADDR_BOOT_FAIL:
                        rsp_nxt.data[boot_status_pkg::BIT_BOOT_FAILED] = failed_r;
                    boot_status_pkg::ADDR_LOAD_STATUS: begin
                        rsp_nxt.data[boot_status_pkg::BIT_LOAD_DONE]   = done_r;
                        rsp_nxt.data[boot_status_pkg::BIT_CHECKSUM_OK] = crc_ok_r;
                    end
                    default: rsp_nxt.data = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    assign reg_rsp = rsp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    chk_fail_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        failed_r |=> failed_r) else $error("boot failed flag dropped");

    chk_fail_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == boot_status_pkg::LOAD_BUSY && load_evt.read_error) |=> failed_r)
        else $error("read error not recorded");

    chk_done_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        done_r |=> done_r) else $error("load done flag dropped");

    chk_done_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == boot_status_pkg::LOAD_BUSY && load_evt.read_done) |=> done_r)
        else $error("load done not recorded");

    chk_crc_tracks_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
        crc_ok_r == !locked_r) else $error("checksum flag and lock disagree");

    chk_lock_refuses: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (locked_r && reg_req.rd) |=> (rsp_r.refused && !rsp_r.ack && rsp_r.data == 8'h00))
        else $error("locked port answered a read");

    chk_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!locked_r && reg_req.rd && reg_req.addr == boot_status_pkg::ADDR_GLOBAL_RSVD)
        |=> (rsp_r.ack && rsp_r.data == 8'h00)) else $error("reserved byte not zero");

    chk_start_after_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(start_r) |-> (!done_r && !failed_r && crc_ok_r && !locked_r) ##1 !start_r)
        else $error("load start not clean");

    ////////////////////////////////////////////////////////////////////////////
    // Cause and freeze checks

    chk_lock_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == boot_status_pkg::LOAD_BUSY && load_evt.crc_error)
        |=> (locked_r && !crc_ok_r))
        else $error("checksum failure not locked");

    chk_lock_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        locked_r |=> locked_r)
        else $error("port lock dropped");

    chk_ok_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !crc_ok_r |=> !crc_ok_r)
        else $error("checksum flag recovered without reset");

    chk_lock_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(locked_r) |->
        $past(state_r == boot_status_pkg::LOAD_BUSY && load_evt.crc_error))
        else $error("port locked without checksum failure");

    chk_ok_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(crc_ok_r) |->
        $past(state_r == boot_status_pkg::LOAD_BUSY && load_evt.crc_error))
        else $error("checksum flag fell without checksum failure");

    chk_fail_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(failed_r) |->
        $past(state_r == boot_status_pkg::LOAD_BUSY && load_evt.read_error))
        else $error("boot failed flag set without read error");

    chk_done_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(done_r) |->
        $past(state_r == boot_status_pkg::LOAD_BUSY && load_evt.read_done))
        else $error("load done flag set without end of read");

    chk_frozen_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == boot_status_pkg::LOAD_DONE)
        |=> $stable({failed_r, done_r, crc_ok_r, locked_r}))
        else $error("flags moved after the load ended");

    chk_start_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        start_r |-> $past(state_r == boot_status_pkg::LOAD_IDLE))
        else $error("load start outside idle");

    chk_state_legal: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r inside {boot_status_pkg::LOAD_IDLE, boot_status_pkg::LOAD_BUSY,
                        boot_status_pkg::LOAD_DONE})
        else $error("load state out of range");

    ////////////////////////////////////////////////////////////////////////////
    // Read answer checks

    chk_rsp_exclusive: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(rsp_r.ack && rsp_r.refused))
        else $error("read both answered and refused");

    chk_rsp_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !reg_req.rd |=> (!rsp_r.ack && !rsp_r.refused && rsp_r.data == 8'h00))
        else $error("answer without a read");

    chk_ack_open: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!locked_r && reg_req.rd) |=> rsp_r.ack)
        else $error("open port did not answer");

    chk_fail_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!locked_r && reg_req.rd && reg_req.addr == boot_status_pkg::ADDR_BOOT_FAIL)
        |=> (rsp_r.data[boot_status_pkg::BIT_BOOT_FAILED] == $past(failed_r)))
        else $error("boot failed bit misreported");

    chk_status_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!locked_r && reg_req.rd && reg_req.addr == boot_status_pkg::ADDR_LOAD_STATUS)
        |=> (rsp_r.data[boot_status_pkg::BIT_LOAD_DONE] == $past(done_r)
             && rsp_r.data[boot_status_pkg::BIT_CHECKSUM_OK] == $past(crc_ok_r)))
        else $error("load status bits misreported");

endmodule // eeprom_boot_status

// [testbench/loader_model.sv]
module loader_model (
    // Clock and control
    input  wire logic                          sys_clk,
    input  wire logic                          load_start,
    input  wire logic [1:0]                    mode,
    // Read engine events
    output boot_status_pkg::loader_event_t     load_evt = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_r = 4'h0;
    // Ends late, so the status holds its reset values for a while
    // Mode 3 sends both errors one cycle after the read has ended; they must be ignored
    always @(posedge sys_clk) begin
        cnt_r    <= load_start ? 4'h6 : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
        load_evt <= '{cnt_r == 4'h2,
                      (cnt_r == 4'h2 && mode == 2'h1) || (cnt_r == 4'h1 && mode == 2'h3),
                      (cnt_r == 4'h2 && mode == 2'h2) || (cnt_r == 4'h1 && mode == 2'h3)};
    end
endmodule // loader_model

// [testbench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0]  mode;
        logic [15:0] addr;
        logic [9:0]  rsp;
    } row_t;
    logic                           sys_clk = 1'b0;
    logic                           arst_n = 1'b0;
    logic [1:0]                     mode = 2'h0;
    boot_status_pkg::loader_event_t load_evt;
    boot_status_pkg::reg_req_t      reg_req = '0;
    boot_status_pkg::reg_rsp_t      reg_rsp;
    logic                           load_start;
    logic                           locked, failed, done, ok;
    logic [9:0]                     r;
    int                             mismatches = 0;
    int                             cmp_count = 0;
    int                             starts = 0;
    wire logic [9:0]                stat = {6'h0, locked, failed, done, ok};
    // Row response is {ack, refused, data}
    row_t rows [6] = '{
        '{2'h0, 16'h0215, 10'h209},
        '{2'h0, 16'h0214, 10'h200},
        '{2'h0, 16'h0213, 10'h200},
        '{2'h1, 16'h0214, 10'h201},
        '{2'h1, 16'h0215, 10'h209},
        '{2'h2, 16'h0214, 10'h100}
    };
    eeprom_boot_status eeprom_boot_status_inst (
        .sys_clk(sys_clk), .arst_n(arst_n), .load_evt(load_evt), .load_start(load_start),
        .reg_req(reg_req), .reg_rsp(reg_rsp), .port_locked(locked),
        .boot_load_failed(failed), .config_load_done(done), .config_checksum_ok(ok)
    );
    loader_model loader_model_inst (
        .sys_clk(sys_clk), .load_start(load_start), .mode(mode), .load_evt(load_evt)
    );
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Counts load starts so that each restart can be held to exactly one
    always @(posedge sys_clk) begin
        if (load_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    task automatic chk_stat(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t: status %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rsp(input logic [9:0] got, input logic [9:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t: answer %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cnt(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            mismatches++;
            $display("[ERR] %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, output logic [9:0] v);
        @(posedge sys_clk) reg_req <= '{1'b1, a};
        @(posedge sys_clk) reg_req <= '0;
        #1 v = reg_rsp;
    endtask
    // Pulls the reset pin, then waits a bounded time for the new load
    task automatic restart(input logic [1:0] m);
        int n;
        int s0;
        @(posedge sys_clk) arst_n <= 1'b0;
        mode <= m;
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        s0 = starts;
        n = 0;
        while (done !== 1'b1 && n < 30) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk_stat({9'h0, done}, 10'h001);
        chk_cnt(starts - s0, 1);
    endtask
    task automatic final_report;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        #1 chk_stat(stat, 10'h001);
        $display("reset values done");
        foreach (rows[i]) begin
            restart(rows[i].mode);
            rd(rows[i].addr, r);
            chk_rsp(r, rows[i].rsp);
            $display("row %0d done", i);
        end
        restart(2'h2);
        chk_stat(stat, 10'h00a);
        rd(16'h0215, r);
        chk_rsp(r, 10'h100);
        restart(2'h0);
        chk_stat(stat, 10'h003);
        rd(16'h0215, r);
        chk_rsp(r, 10'h209);
        $display("crc lock and retry done");
        restart(2'h3);
        repeat (2) @(posedge sys_clk);
        #1 chk_stat(stat, 10'h003);
        rd(16'h0214, r);
        chk_rsp(r, 10'h200);
        $display("late events done");
        final_report();
    end
    // Whole run is a few microseconds
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
endmodule // tb
